/* inc/sys_config_pkg.sv */
// package: register map, field layout, reset values and carrier types
// ====================================================================
`default_nettype none
package sys_config_pkg;
  // ==================================================================
  // register byte offsets
  localparam logic [3:0] off_config_one = 4'h0;
  localparam logic [3:0] off_page_protect = 4'h4;
  localparam logic [3:0] off_line_low = 4'h8;
  localparam logic [3:0] off_line_mid = 4'hc;
  // ==================================================================
  // writable masks and reset values
  localparam logic [31:0] config_one_mask = 32'hfcdff8c3;
  localparam logic [31:0] config_one_reset = 32'h7c000000;
  localparam logic [31:0] page_protect_mask = 32'h0000000f;
  localparam logic [31:0] line_source_mask = 32'h0000ffff;
  localparam logic [31:0] zero_reset = 32'h00000000;
  // ==================================================================
  // field positions
  localparam int fpu_lsb = 26;
  localparam int enc_lsb = 22;
  localparam int i2c_bit = 20;
  localparam int pin_lsb = 16;
  localparam int second_converter_bit = 15;
  localparam int basic_timer_b_bit = 14;
  localparam int basic_timer_a_bit = 13;
  localparam int light_timer_e_bit = 12;
  localparam int light_timer_d_bit = 11;
  localparam int trig_bit = 7;
  localparam int itr_bit = 6;
  // ==================================================================
  // codes
  localparam logic [1:0] enc_none = 2'h0;
  localparam logic [1:0] enc_timer_a = 2'h1;
  localparam logic [1:0] enc_timer_b = 2'h2;
  localparam logic [2:0] trig_sel_remap = 3'h1;
  localparam logic [2:0] port_f_code = 3'h5;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [1:0] {mem_main_flash, mem_system_flash,
    mem_embedded_sram} mem_map_t;

  typedef struct packed {
    logic [5:0] float_exception_irq_enables;
    logic [1:0] encoder_redirect; // 00 none, 01 timer a, 10 timer b
    logic first_i2c_fast_plus_drive;
    logic [3:0] pin_fast_plus_drive; // pb6..pb9
    logic second_converter_dma_remap;
    logic basic_timer_b_dma_remap;
    logic basic_timer_a_dma_remap;
    logic light_timer_e_dma_remap;
    logic light_timer_d_dma_remap;
    logic converter_trigger_remap;
    logic advanced_timer_trigger_remap;
    mem_map_t mem_map;
    logic [3:0] page_protect;
    logic [3:0] line_source_valid; // per line 0 to 3, 0 when code reserved
    logic [31:0] line_port; // 3-bit port per line in 4-bit slots
  } config_out_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_out_t;
endpackage
`default_nettype wire

/* design/system_config_register_bank.sv */
// system configuration register bank with axi4-lite slave
`default_nettype none

// ====================================================================
// one register word: byte-lane merge of a write, reserved bits kept low
module word_merge #(
  parameter logic [31:0] writable = 32'hffffffff,
  parameter bit set_only = 1'b0
) (
  input wire logic [31:0] current,
  input wire logic [31:0] data,
  input wire logic [3:0] strobe,
  output logic [31:0] merged
);
  logic [31:0] lanes;

  // byte strobes widened to one enable per bit
  assign lanes = {{8{strobe[3]}}, {8{strobe[2]}}, {8{strobe[1]}},
    {8{strobe[0]}}};

  // set-only words gain ones from a write and never lose them
  always_comb
  begin
    if (set_only)
      merged = (current | (data & lanes)) & writable;
    else
      merged = ((current & ~lanes) | (data & lanes)) & writable;
  end
endmodule // word_merge

// ====================================================================
// one line source field: reserved codes fall back to port a
module line_source_decode #(
  parameter int has_port_f = 1
) (
  input wire logic [3:0] code,
  output logic [2:0] port,
  output logic valid
);
  import sys_config_pkg::*;

  // the top code bit is a don't-care; port f is missing on some lines
  always_comb
  begin
    valid = (code[2:0] < port_f_code)
      || (code[2:0] == port_f_code && has_port_f != 0);
    port = valid ? code[2:0] : 3'h0;
  end
endmodule // line_source_decode

// ====================================================================
// one dma request route: plain channel, or the remapped one when set
module dma_channel_select #(
  parameter logic [3:0] plain_channel = 4'h1,
  parameter logic [3:0] remapped_channel = 4'h7
) (
  input wire logic remap,
  output logic [3:0] channel
);
  // a static level that follows the register bit with no delay
  assign channel = remap ? remapped_channel : plain_channel;
endmodule // dma_channel_select

module system_config_register_bank (
  // clock, reset, boot strap levels and converter trigger select
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic boot_pin,
  input wire logic boot_option_bit,
  input wire logic [2:0] converter_trigger_select,
  // axi4-lite write and read channels
  input wire logic awvalid,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic [31:0] araddr,
  input wire logic rready,
  // bus answers and static routing
  output sys_config_pkg::axil_out_t axil,
  output sys_config_pkg::config_out_t cfg,
  output logic [1:0] mem_map_code,
  output logic converter_trigger_from_timer_b,
  output logic [3:0] dma_controller_one_channel_light_timer_e,
  output logic [3:0] dma_controller_one_channel_light_timer_d
);
  import sys_config_pkg::*;

  // ==================================================================
  // state
  typedef struct packed {
    // boot strap load still pending when low
    logic booted;
    // write address and data parked until both have arrived
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // write response, stands until bready
    logic bvalid;
    logic bresp_err;
    // read response, stands until rready
    logic rvalid;
    logic [31:0] rdata;
    logic rresp_err;
    // the four register words, reserved bits kept at zero
    logic [31:0] config_one;
    logic [31:0] page_protect;
    logic [31:0] line_low;
    logic [31:0] line_mid;
  } state_t;

  state_t state;
  state_t next_state;
  logic do_write;
  logic do_read;
  logic [3:0] waddr;
  logic [31:0] wdat;
  logic [3:0] wstb;
  logic [31:0] merged_config_one;
  logic [31:0] merged_page_protect;
  logic [31:0] merged_line_low;
  logic [31:0] merged_line_mid;
  logic [31:0] line_codes;
  logic [2:0] line_port_dec [8];
  logic line_valid_dec [4];

  // ==================================================================
  // write merge per register; the page word only ever gains ones
  word_merge #(
    .writable(config_one_mask),
    .set_only(1'b0)
  ) merge_config_one (
    .current(state.config_one),
    .data(wdat),
    .strobe(wstb),
    .merged(merged_config_one)
  );

  word_merge #(
    .writable(page_protect_mask),
    .set_only(1'b1)
  ) merge_page_protect (
    .current(state.page_protect),
    .data(wdat),
    .strobe(wstb),
    .merged(merged_page_protect)
  );

  word_merge #(
    .writable(line_source_mask),
    .set_only(1'b0)
  ) merge_line_low (
    .current(state.line_low),
    .data(wdat),
    .strobe(wstb),
    .merged(merged_line_low)
  );

  word_merge #(
    .writable(line_source_mask),
    .set_only(1'b0)
  ) merge_line_mid (
    .current(state.line_mid),
    .data(wdat),
    .strobe(wstb),
    .merged(merged_line_mid)
  );

  // read mux over the four registers
  function automatic logic [32:0] read_reg(input state_t s,
    input logic [3:0] a);
    logic [32:0] r;
    r = {1'b0, 32'h00000000};
    case (a)
      off_config_one: r = {1'b1, s.config_one};
      off_page_protect: r = {1'b1, s.page_protect};
      off_line_low: r = {1'b1, s.line_low};
      off_line_mid: r = {1'b1, s.line_mid};
      // unmapped offsets answer zero with an error response
      default: r = {1'b0, 32'h00000000};
    endcase
    return r;
  endfunction

  // ==================================================================
  // next state
  always_comb
  begin
    logic [32:0] rd;
    rd = 33'h000000000;
    next_state = state;
    waddr = state.aw_held ? state.aw_addr : awaddr[3:0];
    wdat = state.w_held ? state.w_data : wdata;
    wstb = state.w_held ? state.w_strb : wstrb;
    // a write goes ahead once both halves are here and no answer waits
    do_write = (state.aw_held || awvalid) && (state.w_held || wvalid)
      && !state.bvalid;
    // one read at a time; the next address waits for the answer
    do_read = arvalid && !state.rvalid;
    // load boot selection once after reset release
    if (!state.booted)
    begin
      next_state.booted = 1'b1;
      next_state.config_one[1:0] = {boot_option_bit, boot_pin};
    end
    // capture address and data in either order
    if (awvalid && !state.aw_held && !do_write)
    begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = awaddr[3:0];
    end
    if (wvalid && !state.w_held && !do_write)
    begin
      next_state.w_held = 1'b1;
      next_state.w_data = wdata;
      next_state.w_strb = wstrb;
    end
    if (do_write)
    begin
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp_err = 1'b0;
      case (waddr)
        off_config_one:
          next_state.config_one = merged_config_one;
        off_page_protect:
          next_state.page_protect = merged_page_protect;
        off_line_low:
          next_state.line_low = merged_line_low;
        off_line_mid:
          next_state.line_mid = merged_line_mid;
        default: next_state.bresp_err = 1'b1;
      endcase
    end
    else if (state.bvalid && bready)
      next_state.bvalid = 1'b0;
    if (do_read)
    begin
      rd = read_reg(state, araddr[3:0]);
      next_state.rvalid = 1'b1;
      next_state.rdata = rd[31:0];
      next_state.rresp_err = ~rd[32];
    end
    else if (state.rvalid && rready)
      next_state.rvalid = 1'b0;
  end

  // ==================================================================
  // registers
  always_ff @(posedge aclk)
  begin
    // reset clears the handshakes; the boot load follows one edge later
    if (!aresetn)
    begin
      state <= '0;
      state.config_one <= config_one_reset;
      state.page_protect <= zero_reset;
      state.line_low <= zero_reset;
      state.line_mid <= zero_reset;
    end
    else
      state <= next_state;
  end

  // ==================================================================
  // bus outputs
  always_comb
  begin
    // ready falls while an item is parked or an answer waits
    axil.awready = !state.aw_held && !state.bvalid;
    axil.wready = !state.w_held && !state.bvalid;
    // answers come straight from the registered state
    axil.bvalid = state.bvalid;
    axil.bresp = state.bresp_err ? resp_slverr : resp_okay;
    axil.arready = !state.rvalid;
    axil.rvalid = state.rvalid;
    axil.rdata = state.rdata;
    axil.rresp = state.rresp_err ? resp_slverr : resp_okay;
  end

  // ==================================================================
  // static routing outputs decoded from the registers
  always_comb
  begin
    logic [1:0] enc;
    enc = state.config_one[enc_lsb +: 2];
    cfg.float_exception_irq_enables = state.config_one[fpu_lsb +: 6];
    // reserved code 11 means no redirect
    cfg.encoder_redirect = (enc == enc_timer_a || enc == enc_timer_b)
      ? enc : enc_none;
    cfg.first_i2c_fast_plus_drive = state.config_one[i2c_bit];
    cfg.pin_fast_plus_drive = state.config_one[pin_lsb +: 4];
    cfg.second_converter_dma_remap = state.config_one[second_converter_bit];
    cfg.basic_timer_b_dma_remap = state.config_one[basic_timer_b_bit];
    cfg.basic_timer_a_dma_remap = state.config_one[basic_timer_a_bit];
    cfg.light_timer_e_dma_remap = state.config_one[light_timer_e_bit];
    cfg.light_timer_d_dma_remap = state.config_one[light_timer_d_bit];
    cfg.converter_trigger_remap = state.config_one[trig_bit];
    cfg.advanced_timer_trigger_remap = state.config_one[itr_bit];
    // x0 main flash, 01 system flash, 11 sram
    case (state.config_one[1:0])
      2'h1: cfg.mem_map = mem_system_flash;
      2'h3: cfg.mem_map = mem_embedded_sram;
      default: cfg.mem_map = mem_main_flash;
    endcase
    cfg.page_protect = state.page_protect[3:0];
    cfg.line_source_valid = 4'h0;
    for (int i = 0; i < 4; i++)
      cfg.line_source_valid[i] = line_valid_dec[i];
    cfg.line_port = 32'h00000000;
    for (int i = 0; i < 8; i++)
      cfg.line_port[4*i +: 3] = line_port_dec[i];
  end

  // ==================================================================
  // line source decoders, lowest line in the lowest nibble
  assign line_codes = {state.line_mid[15:0], state.line_low[15:0]};
  // lines 3 and 7 have no port f pin, so code x101 is reserved there
  for (genvar g = 0; g < 8; g++)
  begin : gen_line
    if (g < 4)
    begin : gen_low
      line_source_decode #(
        .has_port_f((g == 3) ? 0 : 1)
      ) decode_i (
        .code(line_codes[4*g +: 4]),
        .port(line_port_dec[g]),
        .valid(line_valid_dec[g])
      );
    end
    else
    begin : gen_mid
      // only lines 0 to 3 report a validity flag
      line_source_decode #(
        .has_port_f((g == 7) ? 0 : 1)
      ) decode_i (
        .code(line_codes[4*g +: 4]),
        .port(line_port_dec[g]),
        .valid()
      );
    end
  end

  // routed signals derived from the fields
  assign mem_map_code = state.config_one[1:0];
  assign converter_trigger_from_timer_b = state.config_one[trig_bit]
    && (converter_trigger_select == trig_sel_remap);

  // light timer dma routes on controller one
  dma_channel_select #(
    .plain_channel(4'h1),
    .remapped_channel(4'h7)
  ) route_light_timer_e (
    .remap(state.config_one[light_timer_e_bit]),
    .channel(dma_controller_one_channel_light_timer_e)
  );

  dma_channel_select #(
    .plain_channel(4'h3),
    .remapped_channel(4'h6)
  ) route_light_timer_d (
    .remap(state.config_one[light_timer_d_bit]),
    .channel(dma_controller_one_channel_light_timer_d)
  );
endmodule // system_config_register_bank
`default_nettype wire

/* bench/sys_config_checker_assertions.sv */
// checker: port-level assertions for the register bank
`default_nettype none
module sys_config_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic boot_pin,
  input wire logic boot_option_bit,
  input wire logic [2:0] converter_trigger_select,
  input wire logic awvalid,
  input wire logic wvalid,
  input wire sys_config_pkg::axil_out_t axil,
  input wire sys_config_pkg::config_out_t cfg,
  input wire logic [1:0] mem_map_code,
  input wire logic converter_trigger_from_timer_b,
  input wire logic [3:0] dma_controller_one_channel_light_timer_e,
  input wire logic [3:0] dma_controller_one_channel_light_timer_d
);
  import sys_config_pkg::*;
  // ==================================================================
  // assertions
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_boot_load: assert property ($rose(aresetn) |=>
    mem_map_code == {$past(boot_option_bit), $past(boot_pin)})
    else $error("memory map missed boot selection");
  chk_mem_decode: assert property (cfg.mem_map == (!mem_map_code[0] ?
    mem_main_flash : mem_map_code[1] ? mem_embedded_sram : mem_system_flash))
    else $error("memory map decode wrong");
  chk_page_sticky: assert property ($past(aresetn) |->
    (cfg.page_protect & $past(cfg.page_protect)) == $past(cfg.page_protect))
    else $error("page protect bit cleared");
  chk_trig_remap: assert property (converter_trigger_from_timer_b ==
    (cfg.converter_trigger_remap && converter_trigger_select == 3'h1))
    else $error("converter trigger source wrong");
  chk_dma_e_chan: assert property (dma_controller_one_channel_light_timer_e ==
    (cfg.light_timer_e_dma_remap ? 4'h7 : 4'h1))
    else $error("light timer e channel wrong");
  chk_dma_d_chan: assert property (dma_controller_one_channel_light_timer_d ==
    (cfg.light_timer_d_dma_remap ? 4'h6 : 4'h3))
    else $error("light timer d channel wrong");
  chk_line_port_f: assert property (cfg.line_port[14:12] != 3'h5 &&
    cfg.line_port[30:28] != 3'h5) else $error("port f on line 3 or 7");
  chk_encoder_res: assert property (cfg.encoder_redirect != 2'h3)
    else $error("reserved encoder code routed");
  chk_write_answer: assert property (awvalid && axil.awready &&
    wvalid && axil.wready |=> axil.bvalid) else $error("no write response");
  // main scenarios seen
  cover property (awvalid && axil.awready && wvalid && axil.wready);
  cover property (cfg.page_protect == 4'h7);
  cover property (converter_trigger_from_timer_b);
endmodule // sys_config_checker
bind system_config_register_bank sys_config_checker chk_i (.aclk(aclk),
  .aresetn(aresetn), .boot_pin(boot_pin), .boot_option_bit(boot_option_bit),
  .converter_trigger_select(converter_trigger_select), .awvalid(awvalid),
  .wvalid(wvalid), .axil(axil), .cfg(cfg), .mem_map_code(mem_map_code),
  .converter_trigger_from_timer_b(converter_trigger_from_timer_b),
  .dma_controller_one_channel_light_timer_e(dma_controller_one_channel_light_timer_e),
  .dma_controller_one_channel_light_timer_d(dma_controller_one_channel_light_timer_d));
`default_nettype wire

/* bench/system_config_register_bank_tb_top.sv */
// testbench: register bank exercised over axi4-lite
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module system_config_register_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sys_config_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, boot_pin = 1'b0, boot_option_bit = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, converter_trigger_from_timer_b;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd_d;
  logic [3:0] wstrb = 4'hf, dma_e, dma_d;
  logic [2:0] converter_trigger_select = 3'h0;
  logic [1:0] mem_map_code, resp;
  axil_out_t axil;
  config_out_t cfg;
  mem_map_t exp_map;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  // ==================================================================
  // clock, watchdog and design
  always #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  system_config_register_bank dut (.aclk(aclk), .aresetn(aresetn),
    .boot_pin(boot_pin), .boot_option_bit(boot_option_bit),
    .converter_trigger_select(converter_trigger_select), .awvalid(awvalid),
    .awaddr(awaddr), .wvalid(wvalid), .wdata(wdata), .wstrb(wstrb),
    .bready(bready), .arvalid(arvalid), .araddr(araddr), .rready(rready),
    .axil(axil), .cfg(cfg), .mem_map_code(mem_map_code),
    .converter_trigger_from_timer_b(converter_trigger_from_timer_b),
    .dma_controller_one_channel_light_timer_e(dma_e), .dma_controller_one_channel_light_timer_d(dma_d));
  // ==================================================================
  // bus tasks
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (axil.awready) awvalid <= 1'b0;
      if (axil.wready) wvalid <= 1'b0;
    end while (axil.bvalid !== 1'b1);
    resp = axil.bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (axil.arready) arvalid <= 1'b0;
    end while (axil.rvalid !== 1'b1);
    rd_d = axil.rdata;
    resp = axil.rresp;
    rready <= 1'b0;
  endtask
  task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rd_d, e)
  endtask
  task automatic do_reset(input logic bp, input logic bo);
    @(posedge aclk);
    aresetn <= 1'b0;
    boot_pin <= bp;
    boot_option_bit <= bo;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==================================================================
  // test sequence
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      do_reset(i[0], i[1]);
      chk_rd(32'h0, 32'h7c000000 | 32'(i));
      exp_map = !i[0] ? mem_main_flash : i[1] ? mem_embedded_sram
        : mem_system_flash;
      `CHK(cfg.mem_map, exp_map)
      for (int a = 4; a < 16; a += 4) chk_rd(32'(a), 32'h0);
    end
    $display("test reset values done");
    converter_trigger_select <= 3'h1;
    wr(32'h0, 32'hffffffff, 4'hf);
    `CHK(resp, resp_okay)
    chk_rd(32'h0, 32'hfcdff8c3);
    `CHK(cfg.float_exception_irq_enables, 6'h3f)
    `CHK(cfg[53:42], 12'hfff)
    `CHK({cfg.mem_map, mem_map_code}, {mem_embedded_sram, 2'h3})
    `CHK({converter_trigger_from_timer_b, dma_e, dma_d}, 9'h176)
    converter_trigger_select <= 3'h2;
    wr(32'h0, 32'h0, 4'h8);
    chk_rd(32'h0, 32'h00dff8c3);
    `CHK(converter_trigger_from_timer_b, 1'b0)
    wr(32'h0, 32'h0, 4'hf);
    `CHK({cfg[61:42], dma_e, dma_d}, 28'h13)
    for (int e = 0; e < 4; e++)
    begin
      wr(32'h0, 32'(e) << 22, 4'hf);
      `CHK(cfg.encoder_redirect, e == 3 ? 2'h0 : 2'(e))
    end
    $display("test config one done");
    wr(32'h4, 32'h5, 4'hf);
    wr(32'h4, 32'h0, 4'hf);
    chk_rd(32'h4, 32'h5);
    wr(32'h4, 32'hfffffff2, 4'hf);
    chk_rd(32'h4, 32'h7);
    `CHK(cfg.page_protect, 4'h7)
    $display("test page protect done");
    for (int c = 0; c < 8; c++)
    begin
      wr(32'h8, {16'hffff, {4{4'h8 | 4'(c)}}}, 4'hf);
      wr(32'hc, {16'hffff, {4{4'h8 | 4'(c)}}}, 4'hf);
      chk_rd(32'hc, {16'h0, {4{4'h8 | 4'(c)}}});
      for (int l = 0; l < 8; l++)
        `CHK(cfg.line_port[4*l +: 3],
          (c > 5 || (c == 5 && l % 4 == 3)) ? 3'h0 : 3'(c))
      `CHK(cfg.line_source_valid, c > 5 ? 4'h0 : c == 5 ? 4'h7 : 4'hf)
    end
    $display("test line sources done");
    wr(32'h2, 32'hffffffff, 4'hf);
    `CHK(resp, resp_slverr)
    rd(32'h2);
    `CHK({rd_d, resp}, {32'h0, resp_slverr})
    chk_rd(32'h0, 32'h00c00000);
    do_reset(1'b0, 1'b0);
    chk_rd(32'h4, 32'h0);
    $display("test unmapped and reset done");
    give_verdict();
  end
endmodule // system_config_register_bank_tb_top
`default_nettype wire
